/* File: dv/sai_source.sv */
// Audio source model driving bit clock, word clock and serial data
`timescale 1ns/1ps
`default_nettype none
module sai_source (
  output logic       clk_bclk,
  output logic       word_clock_in,
  output logic [3:0] serial_data_input_pins
);
  logic [23:0] smp [8];

  initial begin
    clk_bclk = 1'b1;
    word_clock_in = 1'b1;
    serial_data_input_pins = 4'h5;
  end

  // Idle data lines toggle; clock runs only inside a call
  task automatic frame(input logic [2:0] fmt, input logic wp, input logic bp, input logic pl);
    int len;
    int p;
    int i;
    int h;
    int o;
    logic [3:0] d;
    len = (fmt == sai_pkg::FMT_TDM) ? 256 : 64;
    h = (fmt == sai_pkg::FMT_TDM) ? 128 : 32;
    o = (fmt == sai_pkg::FMT_LJ) ? 0 : ((fmt == sai_pkg::FMT_RJ24) ? 8 : 1);
    for (int k = -6; k < len + 6; k++) begin
      p = (k < 0 || k >= len) ? len : k;
      i = p % 32;
      d = ~serial_data_input_pins;
      if (p < len && i >= o && i < o + 24) begin
        if (fmt == sai_pkg::FMT_TDM) begin
          d[0] = smp[p / 32][23 + o - i];
        end else begin
          for (int j = 0; j < 4; j++) begin
            d[j] = smp[2 * j + p / 32][23 + o - i];
          end
        end
      end
      clk_bclk = bp;
      // word clock level
      // Right justified idles at the left level so both halves end on an edge
      word_clock_in = wp ^ (pl ? (p != 0) :
                            (p >= h && (p < len || fmt != sai_pkg::FMT_RJ24)));
      serial_data_input_pins = d;
      #62.5;
      clk_bclk = ~bp;
      #62.5;
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/serial_audio_input_port_control_bench.sv */
// Self-checking bench for the serial audio input port
`timescale 1ns/1ps
`default_nettype none
module serial_audio_input_port_control_bench;
  logic                  clk_sys;
  logic                  resetn;
  logic [11:0]           reg_addr;
  logic [7:0]            reg_wdata;
  logic                  reg_we;
  logic                  reg_re;
  logic [7:0]            reg_rdata;
  wire                   clk_bclk;
  wire                   word_clock_in;
  wire [3:0]             sdin;
  logic                  out_valid;
  logic                  out_ready;
  logic                  overrun;
  logic                  stall;
  sai_pkg::sample_word_t out_data;
  sai_pkg::sample_word_t q [$];
  int                    failures;
  int                    checked;
  logic [7:0]            d;
  logic [5:0]            t;
  logic [5:0]            tbl [8] = '{6'h00, 6'h18, 6'h11, 6'h02, 6'h32, 6'h2a, 6'h05, 6'h13};

  serial_audio_input_port_control DUT (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .clk_bclk(clk_bclk),
    .word_clock_in(word_clock_in), .serial_data_input_pins(sdin), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .overrun(overrun)
  );

  sai_source src (
    .clk_bclk(clk_bclk), .word_clock_in(word_clock_in), .serial_data_input_pins(sdin)
  );

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = v;
    reg_we = 1'b1;
    @(negedge clk_sys);
    reg_we = 1'b0;
  endtask

  task automatic reg_read(input logic [11:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge clk_sys);
    reg_re = 1'b0;
    v = reg_rdata;
  endtask

  // Random consumer, held off while stalled
  always @(negedge clk_sys) begin
    out_ready <= ~stall & 1'($urandom);
  end

  // Every accepted word against the queue
  always @(posedge clk_sys) begin
    if (resetn && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check({5'h0, out_data}, {5'h0, q.pop_front()});
      end
    end
  end

  initial begin
    void'($urandom(32'h63b6));
    resetn = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    out_ready = 1'b0;
    stall = 1'b1;
    failures = 0;
    checked = 0;
    fork
      repeat (4) @(posedge clk_sys);
      src.frame(3'b100, 1'b0, 1'b0, 1'b0);
    join
    @(negedge clk_sys);
    resetn = 1'b1;
    stall = 1'b0;
    reg_read(sai_pkg::SER_IN_CTRL_ADDR, d);
    check({24'h0, d}, {24'h0, sai_pkg::SER_IN_CTRL_RESET});
    reg_write(12'h820, 8'h1f);
    reg_read(12'h820, d);
    check({24'h0, d}, 32'h0);
    reg_read(sai_pkg::SER_IN_CTRL_ADDR, d);
    check({24'h0, d}, 32'h0);
    // Stereo, left justified, multiplexed, pulse, reserved, right justified last
    for (int k = 0; k < 8; k++) begin
      t = tbl[k];
      reg_write(sai_pkg::SER_IN_CTRL_ADDR, {3'($urandom), t[4:0]});
      reg_read(sai_pkg::SER_IN_CTRL_ADDR, d);
      check({24'h0, d}, {27'h0, t[4:0]});
      for (int n = 0; n < 8; n++) begin
        src.smp[n] = 24'($urandom);
      end
      if (t[2:0] == 3'b010) begin
        for (int n = 0; n < 8; n++) begin
          q.push_back(sai_pkg::sample_word_t'({n[2:0], src.smp[n]}));
        end
      end else if (t[2] == 1'b0) begin
        for (int s = 0; s < 2; s++) begin
          for (int j = 0; j < 4; j++) begin
            q.push_back(sai_pkg::sample_word_t'({j[1:0], s[0], src.smp[2 * j + s]}));
          end
        end
      end
      stall = (k == 3);
      src.frame(t[2:0], t[4], t[3], t[5]);
      stall = 1'b0;
      repeat (100) @(posedge clk_sys);
      for (int w = 0; w < 3000 && q.size() > 0; w++) begin
        @(posedge clk_sys);
      end
      check(q.size(), 32'h0);
    end
    check({31'h0, overrun}, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire

/* File: logic/sai_pkg.sv */
// Constants and types of the serial audio input port
`default_nettype none
package sai_pkg;
  localparam logic [11:0] SER_IN_CTRL_ADDR  = 12'h81f;
  localparam logic [7:0]  SER_IN_CTRL_RESET = 8'h00;
  localparam int          FMT_LSB           = 0;
  localparam int          FMT_W             = 3;
  localparam int          BIT_POL_POS       = 3;
  localparam int          WORD_POL_POS      = 4;
  localparam int          CFG_W             = 5;
  localparam int          SAMPLE_W          = 24;
  localparam int          NUM_PINS          = 4;
  localparam int          FIFO_DEPTH        = 8;
  localparam logic [7:0]  POS_MSB_I2S       = 8'h01;
  localparam logic [7:0]  POS_LAST_I2S      = 8'h18;
  localparam logic [7:0]  POS_MSB_LJ        = 8'h00;
  localparam logic [7:0]  POS_LAST_LJ       = 8'h17;
  localparam logic [4:0]  TDM_SLOT_MSB      = 5'h01;
  localparam logic [4:0]  TDM_SLOT_LAST     = 5'h18;

  typedef enum logic [2:0] {
    FMT_I2S  = 3'b000,
    FMT_LJ   = 3'b001,
    FMT_TDM  = 3'b010,
    FMT_RJ24 = 3'b011
  } fmt_t;

  typedef struct packed {
    logic       word_pol;
    logic       bit_pol;
    logic [2:0] fmt;
  } cfg_t;

  typedef struct packed {
    logic [2:0]  channel;
    logic [23:0] sample;
  } sample_word_t;
endpackage
`default_nettype wire

/* File: logic/serial_audio_input_port_control.sv */
// Serial audio input port: format register, bit clock receiver, crossing FIFO
// Behaviour
// - Eight bit register, zero reset, top three zero
// - Word clock polarity picks left/right level
// - Multiplexed frame starts after falling edge
// - Inverted polarity: frame starts after rising edge
// - Pulse word clock: first edge starts frame
// - Bit clock polarity selects capture edge
// - Format field selects expected data format
// - Justified formats: word clock high first; code uses the stereo rule, channel 0 where word clock equals word_pol
// - Slot MSB one bit clock late
// - Slots 0-3 first half, 4-7 second
// - Multiplexed stream only on first pin
// - Format codes: stereo, left, multiplexed, right
`timescale 1ns/1ps
`default_nettype none

module async_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input  wire logic             wclk,
  input  wire logic             wrst_n,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rclk,
  input  wire logic             rrst_n,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_q, wbin_d, wgray_q, wgray_d;
  logic [AW:0]      rbin_q, rbin_d, rgray_q, rgray_d;
  logic [AW:0]      rq1_q, rq2_q, wq1_q, wq2_q;

  // Gray pointers cross between domains
  always_comb begin
    wr_ready = (wgray_q != {~rq2_q[AW:AW-1], rq2_q[AW-2:0]});
    rd_valid = (rgray_q != wq2_q);
    rd_data  = mem[rbin_q[AW-1:0]];
    wbin_d   = (wr_valid && wr_ready) ? wbin_q + 1'b1 : wbin_q;
    rbin_d   = (rd_valid && rd_ready) ? rbin_q + 1'b1 : rbin_q;
    wgray_d  = wbin_d ^ (wbin_d >> 1);
    rgray_d  = rbin_d ^ (rbin_d >> 1);
  end

  always_ff @(posedge wclk) begin
    if (wr_valid && wr_ready) begin
      mem[wbin_q[AW-1:0]] <= wr_data;
    end
    if (!wrst_n) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      rq1_q   <= '0;
      rq2_q   <= '0;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= wgray_d;
      rq1_q   <= rgray_q;
      rq2_q   <= rq1_q;
    end
  end

  always_ff @(posedge rclk) begin
    if (!rrst_n) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      wq1_q   <= '0;
      wq2_q   <= '0;
    end else begin
      rbin_q  <= rbin_d;
      rgray_q <= rgray_d;
      wq1_q   <= wgray_q;
      wq2_q   <= wq1_q;
    end
  end
endmodule

module serial_audio_input_port_control (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic [11:0]           reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_we,
  input  wire logic                  reg_re,
  output logic [7:0]                 reg_rdata,
  input  wire logic                  clk_bclk,
  input  wire logic                  word_clock_in,
  input  wire logic [3:0]            serial_data_input_pins,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output sai_pkg::sample_word_t      out_data,
  output logic                       overrun
);
  sai_pkg::cfg_t         cfg_q, cfg_d;
  logic [7:0]            rdata_q, rdata_d;
  logic                  ovr_s1_q, ovr_s2_q;
  logic                  ovr_q, ovr_d;
  logic                  out_valid_q, out_valid_d;
  sai_pkg::sample_word_t out_data_q, out_data_d;
  logic                  fifo_rd_valid, fifo_pop;
  sai_pkg::sample_word_t fifo_rd_data;
  logic                  reg_hit;

  // Register port and output stage
  always_comb begin
    reg_hit     = (reg_addr == sai_pkg::SER_IN_CTRL_ADDR);
    cfg_d       = cfg_q;
    rdata_d     = 8'h00;
    if (reg_we && reg_hit) begin
      cfg_d = sai_pkg::cfg_t'(reg_wdata[sai_pkg::CFG_W-1:0]);
    end
    if (reg_re && reg_hit) begin
      rdata_d = {3'h0, cfg_q};
    end
    fifo_pop    = fifo_rd_valid && (!out_valid_q || out_ready);
    out_valid_d = fifo_pop ? 1'b1 : (out_ready ? 1'b0 : out_valid_q);
    out_data_d  = fifo_pop ? fifo_rd_data : out_data_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_q       <= sai_pkg::cfg_t'(sai_pkg::SER_IN_CTRL_RESET[sai_pkg::CFG_W-1:0]);
      rdata_q     <= 8'h00;
      ovr_s1_q    <= 1'b0;
      ovr_s2_q    <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      cfg_q       <= cfg_d;
      rdata_q     <= rdata_d;
      ovr_s1_q    <= ovr_q;
      ovr_s2_q    <= ovr_s1_q;
      out_valid_q <= out_valid_d;
      out_data_q  <= out_data_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;
  assign overrun   = ovr_s2_q;

  // Link domain on the bit clock
  logic                  lrst_s1_q, lrst_s2_q;
  sai_pkg::cfg_t         cfg_s1_q, cfg_s2_q;
  logic                  lr_n_q;
  logic [3:0]            sd_n_q;
  logic                  lr_prev_q;
  logic [7:0]            cnt_q, cnt_d, pos;
  logic [3:0][23:0]      sh_q, sh_d, hold_q, hold_d;
  logic [3:0]            pend_q, pend_d, pop_mask;
  logic [2:0]            ch_q, ch_d;
  logic                  lr_s, edge_w, fstart, tdm, rj, supported, shift_en, emit, side;
  logic [3:0]            sd_s;
  logic [7:0]            msb_pos, last_pos;
  logic [1:0]            k;
  logic                  wr_valid, wr_ready;
  sai_pkg::sample_word_t wr_data;

  always_ff @(posedge clk_bclk) begin
    lrst_s1_q <= resetn;
    lrst_s2_q <= lrst_s1_q;
    cfg_s1_q  <= cfg_q;
    cfg_s2_q  <= cfg_s1_q;
  end

  always_ff @(negedge clk_bclk) begin
    lr_n_q <= word_clock_in;
    sd_n_q <= serial_data_input_pins;
  end

  always_comb begin
    tdm      = 1'b0;
    rj       = 1'b0;
    supported = 1'b1;
    msb_pos  = sai_pkg::POS_MSB_I2S;
    last_pos = sai_pkg::POS_LAST_I2S;
    unique case (sai_pkg::fmt_t'(cfg_s2_q.fmt))
      sai_pkg::FMT_I2S: begin
        msb_pos  = sai_pkg::POS_MSB_I2S;
        last_pos = sai_pkg::POS_LAST_I2S;
      end
      sai_pkg::FMT_LJ: begin
        msb_pos  = sai_pkg::POS_MSB_LJ;
        last_pos = sai_pkg::POS_LAST_LJ;
      end
      sai_pkg::FMT_TDM:  tdm = 1'b1;
      sai_pkg::FMT_RJ24: rj = 1'b1;
      default: supported = 1'b0;
    endcase
    lr_s   = cfg_s2_q.bit_pol ? lr_n_q : word_clock_in;
    sd_s   = cfg_s2_q.bit_pol ? sd_n_q : serial_data_input_pins;
    edge_w = lr_s ^ lr_prev_q;
    if (tdm) begin
      fstart = cfg_s2_q.word_pol ? (lr_s & ~lr_prev_q) : (~lr_s & lr_prev_q);
    end else begin
      fstart = edge_w;
    end
    pos   = fstart ? 8'h00 : cnt_q;
    cnt_d = fstart ? 8'h01 : 8'(cnt_q + 8'h01);
    if (rj) begin
      shift_en = 1'b1;
      emit     = edge_w;
    end else if (tdm) begin
      shift_en = (pos[4:0] >= sai_pkg::TDM_SLOT_MSB) && (pos[4:0] <= sai_pkg::TDM_SLOT_LAST);
      emit     = (pos[4:0] == sai_pkg::TDM_SLOT_LAST);
    end else begin
      shift_en = (pos >= msb_pos) && (pos <= last_pos);
      emit     = (pos == last_pos);
    end
    emit = emit && supported;
    side = rj ? (lr_prev_q ^ cfg_s2_q.word_pol) : (lr_s ^ cfg_s2_q.word_pol);
    for (int i = 0; i < sai_pkg::NUM_PINS; i++) begin
      sh_d[i] = shift_en ? {sh_q[i][22:0], sd_s[i]} : sh_q[i];
    end
    k = 2'h0;
    for (int i = sai_pkg::NUM_PINS - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        k = 2'(i);
      end
    end
    wr_valid = |pend_q;
    pop_mask = (wr_valid && wr_ready) ? (4'h1 << k) : 4'h0;
    pend_d   = pend_q & ~pop_mask;
    hold_d   = hold_q;
    ch_d     = ch_q;
    ovr_d    = ovr_q;
    if (emit) begin
      ovr_d = ovr_q | (|pend_d);
      pend_d = tdm ? 4'h1 : 4'hf;
      ch_d = tdm ? pos[7:5] : {2'h0, side};
      for (int i = 0; i < sai_pkg::NUM_PINS; i++) begin
        hold_d[i] = rj ? sh_q[i] : {sh_q[i][22:0], sd_s[i]};
      end
    end
    wr_data.channel = tdm ? ch_q : {k, ch_q[0]};
    wr_data.sample  = hold_q[k];
  end

  always_ff @(posedge clk_bclk) begin
    if (!lrst_s2_q) begin
      lr_prev_q <= 1'b0;
      cnt_q     <= 8'h00;
      sh_q      <= '0;
      hold_q    <= '0;
      pend_q    <= 4'h0;
      ch_q      <= 3'h0;
      ovr_q     <= 1'b0;
    end else begin
      lr_prev_q <= lr_s;
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      hold_q    <= hold_d;
      pend_q    <= pend_d;
      ch_q      <= ch_d;
      ovr_q     <= ovr_d;
    end
  end

  async_fifo #(
    .WIDTH ($bits(sai_pkg::sample_word_t)),
    .DEPTH (sai_pkg::FIFO_DEPTH)
  ) u_fifo (
    .wclk     (clk_bclk),
    .wrst_n   (lrst_s2_q),
    .wr_valid (wr_valid),
    .wr_ready (wr_ready),
    .wr_data  (wr_data),
    .rclk     (clk_sys),
    .rrst_n   (resetn),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_pop),
    .rd_data  (fifo_rd_data)
  );

  // Register checks
  property p_reg_read_zero_top;
    @(posedge clk_sys) disable iff (!resetn)
      reg_re && reg_hit |=> reg_rdata == {3'h0, $past(cfg_q)};
  endproperty
  a_reg_read_zero_top: assert property (p_reg_read_zero_top)
    else $error("register read data wrong");

  property p_reg_reset;
    @(posedge clk_sys) !resetn |=> cfg_q == '0 && reg_rdata == 8'h00;
  endproperty
  a_reg_reset: assert property (p_reg_reset)
    else $error("register not cleared by reset");

  property p_reg_write;
    @(posedge clk_sys) disable iff (!resetn)
      reg_we && reg_hit |=> cfg_q == $past(reg_wdata[4:0]);
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("register write lost");

  // Link checks
  property p_tdm_start;
    @(posedge clk_bclk) disable iff (!lrst_s2_q)
      tdm && fstart |-> (cfg_s2_q.word_pol ? lr_s : !lr_s) && edge_w;
  endproperty
  a_tdm_start: assert property (p_tdm_start)
    else $error("frame started on wrong word clock edge");

  property p_pulse_second_edge;
    @(posedge clk_bclk) disable iff (!lrst_s2_q)
      tdm && edge_w && !fstart |=> cnt_q == 8'($past(cnt_q) + 8'h01);
  endproperty
  a_pulse_second_edge: assert property (p_pulse_second_edge)
    else $error("trailing pulse edge restarted frame");

  property p_tdm_slot_last;
    @(posedge clk_bclk) disable iff (!lrst_s2_q)
      tdm && emit |=> ch_q == $past(pos[7:5]) && pend_q == 4'h1;
  endproperty
  a_tdm_slot_last: assert property (p_tdm_slot_last)
    else $error("slot channel or pin mask wrong");

  property p_tdm_msb_delay;
    @(posedge clk_bclk) disable iff (!lrst_s2_q)
      tdm && emit |-> pos[4:0] == 5'h18;
  endproperty
  a_tdm_msb_delay: assert property (p_tdm_msb_delay)
    else $error("slot word ended at wrong bit");

  property p_i2s_last;
    @(posedge clk_bclk) disable iff (!lrst_s2_q)
      cfg_s2_q.fmt == 3'b000 && emit |-> pos == 8'h18;
  endproperty
  a_i2s_last: assert property (p_i2s_last)
    else $error("stereo word ended at wrong bit");

  property p_side;
    @(posedge clk_bclk) disable iff (!lrst_s2_q)
      !tdm && !rj && emit |=> ch_q[0] == ($past(lr_s) ^ $past(cfg_s2_q.word_pol));
  endproperty
  a_side: assert property (p_side)
    else $error("channel side wrong");

  property p_reserved_idle;
    @(posedge clk_bclk) disable iff (!lrst_s2_q)
      cfg_s2_q.fmt[2] |-> !emit;
  endproperty
  a_reserved_idle: assert property (p_reserved_idle)
    else $error("reserved format captured data");

  property p_edge_select;
    @(posedge clk_bclk) disable iff (!lrst_s2_q)
      cfg_s2_q.bit_pol && $stable(cfg_s2_q) |-> sd_s == sd_n_q;
  endproperty
  a_edge_select: assert property (p_edge_select)
    else $error("capture edge not the selected one");

  c_tdm_emit: cover property (@(posedge clk_bclk) disable iff (!lrst_s2_q) tdm && emit);
  c_stereo_emit: cover property (@(posedge clk_bclk) disable iff (!lrst_s2_q) !tdm && emit);
  c_overrun: cover property (@(posedge clk_bclk) disable iff (!lrst_s2_q) ovr_d && !ovr_q);
  c_out_take: cover property (@(posedge clk_sys) disable iff (!resetn) out_valid && out_ready);
endmodule

`default_nettype wire
